// ### pkg/oag_pkg.sv
package oag_pkg;
	localparam int DATA_W = 16;
	localparam int NUM_PTR = 8;
	localparam int NUM_ACC = 32;
	localparam int NUM_AP = 4;
	localparam int NEXTA_LSB = 10;
	localparam int NEXTA_MSB = 11;
	localparam int INDEX_PTR = 5;
	localparam int PAGE_PTR = 6;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] BYTE_STEP = 16'h0001;
	localparam logic [4:0] OFFSET_DIST = 5'h10;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [4:0] RST_AP = 5'h00;
	localparam logic [31:0] ROUND_BIAS = 32'h0000_8000;

	typedef enum logic [1:0] {
		NA_NONE = 2'b00,
		NA_DEC = 2'b01,
		NA_INC = 2'b10,
		NA_STRING = 2'b11
	} oag_nexta_e;

	typedef enum logic [2:0] {
		AM_IMM,
		AM_DIRECT,
		AM_IND,
		AM_IND_INC,
		AM_IND_DEC,
		AM_IND_IDX,
		AM_TABLE,
		AM_ROUNDED_MULTIPLY_OP
	} oag_mode_e;

	typedef struct packed {
		oag_mode_e mode;
		logic two_word;
		logic byte_op;
		logic [2:0] ptr_sel;
		logic [1:0] ap_sel;
		logic [15:0] opcode;
		logic [15:0] imm;
	} oag_instr_s;

	typedef struct packed {
		logic valid;
		logic [15:0] operand;
		logic [15:0] addr;
		logic [4:0] acc_sel;
		logic [4:0] acc_offset_sel;
		logic string_mode;
	} oag_result_s;
endpackage : oag_pkg

// ### core/oag_core.sv
`timescale 1ns/1ps
module oag_core import oag_pkg::*; (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Instruction from decoder
	input wire logic instr_valid_i,
	input wire oag_instr_s instr_i,
	input wire logic [15:0] second_word_i,
	// Accumulator contents for table lookup
	input wire logic [15:0] acc_value_i,
	// Memory read data
	input wire logic [15:0] dmem_rdata_i,
	input wire logic [15:0] pmem_rdata_i,
	// Pointer load from core
	input wire logic ptr_load_i,
	input wire logic [2:0] ptr_load_sel_i,
	input wire logic [15:0] ptr_load_data_i,
	input wire logic mr_load_i,
	input wire logic [15:0] mr_load_data_i,
	// Results
	output oag_result_s result_o,
	output logic busy_o,
	output logic second_fetch_o,
	// Data memory
	output logic dmem_re_o,
	output logic dmem_we_o,
	output logic [15:0] dmem_addr_o,
	output logic [15:0] dmem_wdata_o,
	// Program memory
	output logic pmem_re_o,
	output logic [15:0] pmem_addr_o,
	// Product high and pointer view
	output logic [15:0] product_high_reg_o,
	output logic [15:0] index_pointer_o,
	output logic [15:0] page_pointer_o
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SECOND,
		ST_TABLE
	} oag_state_e;

	oag_state_e state, next_state;
	oag_instr_s held, next_held;
	logic [15:0] ptr [NUM_PTR];
	logic [15:0] next_ptr [NUM_PTR];
	logic [4:0] ap [NUM_AP];
	logic [4:0] next_ap [NUM_AP];
	logic [15:0] multiplier_operand_reg, next_mr;
	logic [15:0] product_high_reg, next_ph;
	logic [15:0] table_dest, next_table_dest;
	oag_result_s next_result;
	logic next_busy, next_second_fetch;
	logic next_dmem_re, next_dmem_we, next_pmem_re;
	logic [15:0] next_dmem_addr, next_dmem_wdata, next_pmem_addr;
	logic mul_pending, next_mul_pending;
	logic take;
	logic [1:0] instr_code;

	assign take = (state == ST_IDLE) && instr_valid_i;
	assign instr_code = instr_i.opcode[NEXTA_MSB:NEXTA_LSB];

	function automatic logic [4:0] ap_premod(input logic [4:0] cur, input logic [1:0] code);
		unique case (code)
			NA_DEC: ap_premod = cur - 5'h01;
			NA_INC: ap_premod = cur + 5'h01;
			default: ap_premod = cur;
		endcase
	endfunction : ap_premod

	function automatic logic [15:0] mul_round(input logic [15:0] a, input logic [15:0] b);
		logic [31:0] prod;
		prod = {16'h0000, a} * {16'h0000, b};
		prod = prod + ROUND_BIAS;
		mul_round = prod[31:16];
	endfunction : mul_round

	function automatic logic string_code(input logic [15:0] op);
		string_code = (op[NEXTA_MSB:NEXTA_LSB] == NA_STRING);
	endfunction : string_code

	always_comb begin
		logic [1:0] code;
		logic [4:0] sel;
		logic [15:0] base;
		code = 2'b00;
		sel = RST_AP;
		base = RST_WORD;
		next_state = state;
		next_held = held;
		next_table_dest = table_dest;
		next_result = '0;
		next_busy = 1'b0;
		next_second_fetch = 1'b0;
		next_dmem_re = 1'b0;
		next_dmem_we = 1'b0;
		next_pmem_re = 1'b0;
		next_dmem_addr = dmem_addr_o;
		next_dmem_wdata = dmem_wdata_o;
		next_pmem_addr = pmem_addr_o;
		next_mul_pending = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (instr_valid_i) begin
					code = instr_code;
					sel = ap_premod(ap[instr_i.ap_sel], code);
					next_result.acc_sel = sel;
					next_result.acc_offset_sel = sel + OFFSET_DIST;
					next_result.string_mode = string_code(instr_i.opcode);
					next_held = instr_i;
					base = ptr[instr_i.ptr_sel];
					unique case (instr_i.mode)
						AM_IMM: begin
							if (instr_i.two_word) begin
								next_state = ST_SECOND;
								next_busy = 1'b1;
								next_second_fetch = 1'b1;
							end else begin
								next_result.valid = 1'b1;
								next_result.operand = instr_i.imm;
							end
						end
						AM_DIRECT, AM_TABLE, AM_ROUNDED_MULTIPLY_OP: begin
							next_state = ST_SECOND;
							next_busy = 1'b1;
							next_second_fetch = 1'b1;
						end
						AM_IND, AM_IND_INC, AM_IND_DEC, AM_IND_IDX: begin
							next_result.valid = 1'b1;
							next_result.addr = base;
							next_dmem_addr = base;
							next_dmem_re = 1'b1;
						end
					endcase
				end
			end
			ST_SECOND: begin
				next_state = ST_IDLE;
				next_result.acc_sel = ap[held.ap_sel];
				next_result.acc_offset_sel = ap[held.ap_sel] + OFFSET_DIST;
				next_result.string_mode = string_code(held.opcode);
				unique case (held.mode)
					AM_IMM: begin
						next_result.valid = 1'b1;
						next_result.operand = second_word_i;
					end
					AM_TABLE: begin
						next_state = ST_TABLE;
						next_busy = 1'b1;
						next_table_dest = second_word_i;
						next_pmem_addr = acc_value_i;
						next_pmem_re = 1'b1;
					end
					default: begin
						next_result.valid = 1'b1;
						next_result.addr = second_word_i;
						next_dmem_addr = second_word_i;
						next_dmem_re = 1'b1;
						next_mul_pending = (held.mode == AM_ROUNDED_MULTIPLY_OP);
					end
				endcase
			end
			ST_TABLE: begin
				next_state = ST_IDLE;
				next_result.acc_sel = ap[held.ap_sel];
				next_result.acc_offset_sel = ap[held.ap_sel] + OFFSET_DIST;
				next_result.string_mode = string_code(held.opcode);
				next_result.valid = 1'b1;
				next_result.addr = table_dest;
				next_dmem_addr = table_dest;
				next_dmem_wdata = pmem_rdata_i;
				next_dmem_we = 1'b1;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			held <= '0;
			table_dest <= RST_WORD;
			result_o <= '0;
			busy_o <= 1'b0;
			second_fetch_o <= 1'b0;
			dmem_re_o <= 1'b0;
			dmem_we_o <= 1'b0;
			dmem_addr_o <= RST_WORD;
			dmem_wdata_o <= RST_WORD;
			pmem_re_o <= 1'b0;
			pmem_addr_o <= RST_WORD;
			mul_pending <= 1'b0;
		end else begin
			state <= next_state;
			held <= next_held;
			table_dest <= next_table_dest;
			result_o <= next_result;
			busy_o <= next_busy;
			second_fetch_o <= next_second_fetch;
			dmem_re_o <= next_dmem_re;
			dmem_we_o <= next_dmem_we;
			dmem_addr_o <= next_dmem_addr;
			dmem_wdata_o <= next_dmem_wdata;
			pmem_re_o <= next_pmem_re;
			pmem_addr_o <= next_pmem_addr;
			mul_pending <= next_mul_pending;
		end
	end

	// Pointer registers; a post-modify beats a load of the same pointer
	always_comb begin
		logic [15:0] base;
		logic [15:0] step;
		base = ptr[instr_i.ptr_sel];
		step = instr_i.byte_op ? BYTE_STEP : WORD_STEP;
		for (int i = 0; i < NUM_PTR; i++) begin
			next_ptr[i] = ptr[i];
		end
		if (ptr_load_i) begin
			next_ptr[ptr_load_sel_i] = ptr_load_data_i;
		end
		if (take) begin
			if (instr_i.mode == AM_IND_INC) begin
				next_ptr[instr_i.ptr_sel] = base + step;
			end else if (instr_i.mode == AM_IND_DEC) begin
				next_ptr[instr_i.ptr_sel] = base - step;
			end else if (instr_i.mode == AM_IND_IDX) begin
				next_ptr[instr_i.ptr_sel] = base + ptr[INDEX_PTR];
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_PTR; i++) begin
				ptr[i] <= RST_WORD;
			end
			index_pointer_o <= RST_WORD;
			page_pointer_o <= RST_WORD;
		end else begin
			for (int i = 0; i < NUM_PTR; i++) begin
				ptr[i] <= next_ptr[i];
			end
			index_pointer_o <= next_ptr[INDEX_PTR];
			page_pointer_o <= next_ptr[PAGE_PTR];
		end
	end

	// Accumulator pointers, premodified when an instruction is taken
	always_comb begin
		for (int i = 0; i < NUM_AP; i++) begin
			next_ap[i] = ap[i];
		end
		if (take) begin
			next_ap[instr_i.ap_sel] = ap_premod(ap[instr_i.ap_sel], instr_code);
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_AP; i++) begin
				ap[i] <= RST_AP;
			end
		end else begin
			for (int i = 0; i < NUM_AP; i++) begin
				ap[i] <= next_ap[i];
			end
		end
	end

	// Multiplier operand and rounded product
	always_comb begin
		next_mr = multiplier_operand_reg;
		next_ph = product_high_reg;
		if (mr_load_i) begin
			next_mr = mr_load_data_i;
		end
		if (mul_pending) begin
			next_ph = mul_round(multiplier_operand_reg, dmem_rdata_i);
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			multiplier_operand_reg <= RST_WORD;
			product_high_reg <= RST_WORD;
			product_high_reg_o <= RST_WORD;
		end else begin
			multiplier_operand_reg <= next_mr;
			product_high_reg <= next_ph;
			product_high_reg_o <= next_ph;
		end
	end
endmodule : oag_core

// ### testbench/oag_mem_model.sv
`timescale 1ns/1ps
module oag_mem_model (
	// Requests
	input wire logic dmem_re_i,
	input wire logic [15:0] dmem_addr_i,
	input wire logic pmem_re_i,
	input wire logic [15:0] pmem_addr_i,
	// Read data
	output logic [15:0] dmem_rdata_o,
	output logic [15:0] pmem_rdata_o
);
	// Data word while the strobe is high, else the inverse
	assign dmem_rdata_o = dmem_re_i ? {dmem_addr_i[7:0], dmem_addr_i[15:8]} :
		~{dmem_addr_i[7:0], dmem_addr_i[15:8]};
	// Program word while the strobe is high
	assign pmem_rdata_o = pmem_re_i ? (pmem_addr_i ^ 16'h5a5a) : ~pmem_addr_i;
endmodule : oag_mem_model

// ### testbench/oag_core_monitor.sv
`timescale 1ns/1ps
module oag_core_monitor import oag_pkg::*; (
	// Clock, reset, inputs
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic instr_valid_i,
	input wire oag_instr_s instr_i,
	input wire logic [15:0] second_word_i,
	input wire logic [15:0] acc_value_i,
	input wire logic [15:0] pmem_rdata_i,
	// Outputs
	input wire oag_result_s result_o,
	input wire logic busy_o,
	input wire logic second_fetch_o,
	input wire logic dmem_re_o,
	input wire logic dmem_we_o,
	input wire logic [15:0] dmem_addr_o,
	input wire logic [15:0] dmem_wdata_o,
	input wire logic pmem_re_o,
	input wire logic [15:0] pmem_addr_o,
	input wire logic [15:0] index_pointer_o,
	input wire logic [15:0] page_pointer_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	logic tk;
	logic [15:0] st;
	assign tk = instr_valid_i && !busy_o;
	assign st = instr_i.byte_op ? BYTE_STEP : WORD_STEP;
	sequence s_tab_fetch;
		##2 pmem_re_o && pmem_addr_o == $past(acc_value_i);
	endsequence
	sequence s_tab_write;
		##1 dmem_we_o && dmem_wdata_o == $past(pmem_rdata_i);
	endsequence
	chk_imm_one: assert property (
		tk && instr_i.mode == AM_IMM && !instr_i.two_word
		|=> result_o.valid && result_o.operand == $past(instr_i.imm)) else $error("imm late");
	chk_direct_word: assert property (
		tk && instr_i.mode == AM_DIRECT |=> second_fetch_o
		##1 result_o.valid && dmem_addr_o == $past(second_word_i)) else $error("direct bad");
	chk_post_inc: assert property (
		tk && instr_i.mode == AM_IND_INC && instr_i.ptr_sel == 3'd5
		|=> dmem_addr_o == $past(index_pointer_o)
		&& index_pointer_o == $past(index_pointer_o) + $past(st)) else $error("inc bad");
	chk_post_dec: assert property (
		tk && instr_i.mode == AM_IND_DEC && instr_i.ptr_sel == 3'd6
		|=> dmem_addr_o == $past(page_pointer_o)
		&& page_pointer_o == $past(page_pointer_o) - $past(st)) else $error("dec bad");
	chk_idx_add: assert property (
		tk && instr_i.mode == AM_IND_IDX && instr_i.ptr_sel == 3'd6
		|=> page_pointer_o == $past(page_pointer_o) + $past(index_pointer_o))
		else $error("index bad");
	chk_acc_pair: assert property (
		result_o.valid |-> result_o.acc_offset_sel == result_o.acc_sel + OFFSET_DIST)
		else $error("offset bad");
	chk_str_flag: assert property (
		tk && instr_i.mode == AM_IND && instr_i.opcode[NEXTA_MSB:NEXTA_LSB] == NA_STRING
		|=> result_o.string_mode) else $error("string bad");
	chk_table_seq: assert property (
		tk && instr_i.mode == AM_TABLE |-> s_tab_fetch ##0 s_tab_write) else $error("table bad");
	chk_read_strobe: assert property (
		tk && instr_i.mode inside {AM_IND, AM_IND_INC, AM_IND_DEC, AM_IND_IDX}
		|=> dmem_re_o && !dmem_we_o) else $error("read strobe bad");
endmodule : oag_core_monitor
bind oag_core oag_core_monitor oag_core_monitor_inst (.clock_i, .rst_i, .instr_valid_i,
	.instr_i, .second_word_i, .acc_value_i, .pmem_rdata_i, .result_o, .busy_o,
	.second_fetch_o, .dmem_re_o, .dmem_we_o, .dmem_addr_o, .dmem_wdata_o, .pmem_re_o,
	.pmem_addr_o, .index_pointer_o, .page_pointer_o);

// ### testbench/oag_core_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
	$display("Error at %0t: got %h, expected %h", $time, (a), (b)); end end
module oag_core_bench import oag_pkg::*;;
	typedef struct packed {logic k; logic s; logic [15:0] v; logic [4:0] a;} oag_exp_s;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic instr_valid_i = 1'b0;
	oag_instr_s instr_i = '0;
	logic [15:0] second_word_i = 16'h0000, acc_value_i = 16'h0000;
	logic ptr_load_i = 1'b0, mr_load_i = 1'b0;
	logic [2:0] ptr_load_sel_i = 3'h0;
	logic [15:0] ptr_load_data_i = 16'h0000, mr_load_data_i = 16'h0000;
	logic [15:0] dmem_rdata_i, pmem_rdata_i, dmem_addr_o, dmem_wdata_o, pmem_addr_o;
	logic [15:0] product_high_reg_o, index_pointer_o, page_pointer_o, mr;
	logic busy_o, second_fetch_o, dmem_re_o, dmem_we_o, pmem_re_o;
	oag_result_s result_o;
	int fail_count = 0, comparisons = 0;
	logic [31:0] rs = 32'h0000_e4e0;
	logic [15:0] ptr [8];
	logic [4:0] ap [4] = '{default: 5'h00};
	oag_exp_s q [$];
	oag_exp_s em;
	oag_core oag_core_inst (.clock_i, .rst_i, .instr_valid_i, .instr_i, .second_word_i,
		.acc_value_i, .dmem_rdata_i, .pmem_rdata_i, .ptr_load_i, .ptr_load_sel_i,
		.ptr_load_data_i, .mr_load_i, .mr_load_data_i, .result_o, .busy_o, .second_fetch_o,
		.dmem_re_o, .dmem_we_o, .dmem_addr_o, .dmem_wdata_o, .pmem_re_o, .pmem_addr_o,
		.product_high_reg_o, .index_pointer_o, .page_pointer_o);
	oag_mem_model oag_mem_model_inst (.dmem_re_i(dmem_re_o), .dmem_addr_i(dmem_addr_o),
		.pmem_re_i(pmem_re_o), .pmem_addr_i(pmem_addr_o), .dmem_rdata_o(dmem_rdata_i),
		.pmem_rdata_o(pmem_rdata_i));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task end_sim;
		$display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic issue(input oag_mode_e m);
		oag_instr_s i;
		oag_exp_s e;
		int w;
		logic [15:0] s;
		logic [15:0] st;
		logic [31:0] p;
		rs = lfsr(rs);
		i = '0;
		i.mode = m;
		i.byte_op = rs[0];
		i.ptr_sel = rs[3:1];
		i.ap_sel = rs[5:4];
		i.opcode[11:10] = rs[7:6];
		i.imm = rs[31:16];
		i.two_word = (m == AM_IMM) ? rs[8] : (m inside {AM_DIRECT, AM_TABLE, AM_ROUNDED_MULTIPLY_OP});
		s = (m == AM_IMM) ? i.imm : rs[23:8];
		st = i.byte_op ? BYTE_STEP : WORD_STEP;
		if (rs[7:6] == 2'b01) ap[i.ap_sel] = ap[i.ap_sel] - 5'h01;
		if (rs[7:6] == 2'b10) ap[i.ap_sel] = ap[i.ap_sel] + 5'h01;
		e = {m == AM_IMM, rs[7:6] == 2'b11, (m == AM_IMM) ? i.imm : s, ap[i.ap_sel]};
		if (m inside {AM_IND, AM_IND_INC, AM_IND_DEC, AM_IND_IDX}) e.v = ptr[i.ptr_sel];
		if (m == AM_IND_INC) ptr[i.ptr_sel] = ptr[i.ptr_sel] + st;
		if (m == AM_IND_DEC) ptr[i.ptr_sel] = ptr[i.ptr_sel] - st;
		if (m == AM_IND_IDX) ptr[i.ptr_sel] = ptr[i.ptr_sel] + ptr[5];
		w = !i.two_word ? 0 : (m == AM_TABLE) ? 3 : (m == AM_ROUNDED_MULTIPLY_OP) ? 5 : 2;
		q.push_back(e);
		@(posedge clock_i);
		instr_i <= i;
		instr_valid_i <= 1'b1;
		second_word_i <= s;
		acc_value_i <= rs[15:0];
		if (w > 0) begin
			@(posedge clock_i);
			instr_valid_i <= 1'b0;
			repeat (w - 1) @(posedge clock_i);
		end
		if (m == AM_ROUNDED_MULTIPLY_OP) begin
			p = mr * {s[7:0], s[15:8]} + ROUND_BIAS;
			@(negedge clock_i);
			`CHK(product_high_reg_o, p[31:16])
		end
	endtask : issue
	always @(posedge clock_i) begin
		if (result_o.valid === 1'b1) begin
			em = q.pop_front();
			`CHK(em.k ? result_o.operand : result_o.addr, em.v)
			`CHK(result_o.acc_sel, em.a)
			`CHK(result_o.string_mode, em.s)
		end
	end
	initial begin
		forever #10 clock_i = ~clock_i;
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		fail_count++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		for (int n = 0; n < 8; n++) begin
			@(posedge clock_i);
			rs = lfsr(rs);
			ptr_load_i <= 1'b1;
			ptr_load_sel_i <= 3'(n);
			ptr_load_data_i <= rs[15:0];
			ptr[n] = rs[15:0];
			mr_load_i <= 1'b1;
			mr_load_data_i <= rs[31:16];
			mr = rs[31:16];
		end
		@(posedge clock_i);
		ptr_load_i <= 1'b0;
		mr_load_i <= 1'b0;
		for (int n = 0; n < 400; n++) begin
			rs = lfsr(rs);
			issue(oag_mode_e'(rs[2:0]));
		end
		@(posedge clock_i);
		instr_valid_i <= 1'b0;
		repeat (6) @(negedge clock_i);
		`CHK(index_pointer_o, ptr[5])
		`CHK(page_pointer_o, ptr[6])
		`CHK(q.size(), 0)
		end_sim();
	end
endmodule : oag_core_bench
